/* hdl/dtc_pkg.sv */
package dtc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_T0_LOW = 8'h8a;
  localparam logic [7:0] IDX_T1_LOW = 8'h8b;
  localparam logic [7:0] IDX_T0_HIGH = 8'h8c;
  localparam logic [7:0] IDX_T1_HIGH = 8'h8d;
  localparam logic [7:0] IDX_PORT_MODE = 8'h96;
  localparam logic [7:0] IDX_CONTROL = 8'ha0;
  localparam logic [7:0] IDX_STATUS = 8'ha1;
  localparam logic [7:0] IDX_MASK = 8'ha2;

  // Reset values
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_PORT_MODE = 8'h00;
  localparam logic [5:0] RST_CONTROL = 6'h00;
  localparam logic [1:0] RST_FLAGS = 2'h0;

  // Port mode register: toggle enables
  localparam int BIT_T0_TOGGLE_EN = 2;
  localparam int BIT_T1_TOGGLE_EN = 3;

  // Control register: per timer n, bit n + offset
  localparam int BIT_RUN = 0;
  localparam int BIT_GATE = 2;
  localparam int BIT_CT_SEL = 4;

  // Mode 0 geometry
  localparam int PRESCALE_BITS = 5;
  localparam logic [4:0] PRESCALE_MAX = 5'h1f;
  localparam logic [7:0] HIGH_MAX = 8'hff;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
endpackage

/* hdl/dtc_unit_if.sv */
`timescale 1ns/10ps
interface dtc_unit_if;
  logic count_en;
  logic wr_low;
  logic wr_high;
  logic [7:0] wdata;
  logic [7:0] count_low;
  logic [7:0] count_high;
  logic overflow;

  modport ctrl (
    output count_en,
    output wr_low,
    output wr_high,
    output wdata,
    input count_low,
    input count_high,
    input overflow
  );
  modport unit (
    input count_en,
    input wr_low,
    input wr_high,
    input wdata,
    output count_low,
    output count_high,
    output overflow
  );
endinterface

/* hdl/dtc_unit.sv */
`timescale 1ns/10ps
module dtc_unit (
  input wire logic clock,
  input wire logic rstn,
  dtc_unit_if.unit u
);
  logic [7:0] low;
  logic [7:0] high;
  logic ovf;
  logic pre_wrap;

  assign pre_wrap = (low[4:0] == dtc_pkg::PRESCALE_MAX);

  // Upper three low bits are storage only in mode 0
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      low <= dtc_pkg::RST_COUNT;
    end else if (u.wr_low) begin
      low <= u.wdata;
    end else if (u.count_en) begin
      low[4:0] <= low[4:0] + 5'h01;
    end
  end

  // Software write wins over a count in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      high <= dtc_pkg::RST_COUNT;
    end else if (u.wr_high) begin
      high <= u.wdata;
    end else if (u.count_en && pre_wrap && !u.wr_low) begin
      // A low byte write swallows the whole step, carry included
      high <= high + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ovf <= 1'b0;
    end else begin
      ovf <= u.count_en && pre_wrap && !u.wr_high && !u.wr_low &&
          (high == dtc_pkg::HIGH_MAX);
    end
  end

  assign u.count_low = low;
  assign u.count_high = high;
  assign u.overflow = ovf;
endmodule

/* hdl/dtc_top.sv */
`timescale 1ns/10ps
module dtc_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [dtc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [dtc_pkg::DATA_W-1:0] avs_writedata,
  output logic [dtc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  input wire logic external_gate_pin0,
  input wire logic external_gate_pin1,
  output logic timer0_toggle_out,
  output logic timer1_toggle_out,
  output logic irq
);
  logic [7:0] port_mode_and_toggle_enable;
  logic [5:0] control;
  logic [1:0] overflow_flag;
  logic [1:0] mask;
  logic [1:0] cnt_s1, cnt_s2, cnt_s3;
  logic [1:0] gate_s1, gate_s2;
  logic [1:0] ovf;
  logic [1:0] count_en;
  logic [1:0] toggle;
  logic [7:0] idx;
  logic accept_wr;
  logic capture_rd;
  logic [7:0] lows [2];
  logic [7:0] highs [2];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  assign idx = avs_address[9:2];
  assign accept_wr = avs_write && !avs_waitrequest;
  assign capture_rd = avs_read && avs_waitrequest;

  // One wait state per access, then one acceptance edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // Pins are asynchronous; third stage feeds edge detect only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_s1 <= 2'h0;
      cnt_s2 <= 2'h0;
      cnt_s3 <= 2'h0;
      gate_s1 <= 2'h0;
      gate_s2 <= 2'h0;
    end else begin
      cnt_s1 <= {timer1_count_pin, timer0_count_pin};
      cnt_s2 <= cnt_s1;
      cnt_s3 <= cnt_s2;
      gate_s1 <= {external_gate_pin1, external_gate_pin0};
      gate_s2 <= gate_s1;
    end
  end

  genvar n;
  generate
    for (n = 0; n < 2; n++) begin : g_timer
      dtc_unit_if uif ();
      logic src;
      logic gate_ok;
      // Falling edge on pin when counter mode, else every clock
      assign src = control[dtc_pkg::BIT_CT_SEL+n] ? (cnt_s3[n] && !cnt_s2[n])
                                                  : 1'b1;
      assign gate_ok = !control[dtc_pkg::BIT_GATE+n] || gate_s2[n];
      assign count_en[n] = control[dtc_pkg::BIT_RUN+n] && gate_ok && src;
      assign uif.count_en = count_en[n];
      assign uif.wr_low = accept_wr &&
          hit(idx, n == 0 ? dtc_pkg::IDX_T0_LOW : dtc_pkg::IDX_T1_LOW);
      assign uif.wr_high = accept_wr &&
          hit(idx, n == 0 ? dtc_pkg::IDX_T0_HIGH : dtc_pkg::IDX_T1_HIGH);
      assign uif.wdata = avs_writedata[7:0];
      assign lows[n] = uif.count_low;
      assign highs[n] = uif.count_high;
      assign ovf[n] = uif.overflow;
      dtc_unit u_unit (
        .clock(clock),
        .rstn(rstn),
        .u(uif)
      );
    end
  endgenerate

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      port_mode_and_toggle_enable <= dtc_pkg::RST_PORT_MODE;
    end else if (accept_wr && hit(idx, dtc_pkg::IDX_PORT_MODE)) begin
      port_mode_and_toggle_enable <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      control <= dtc_pkg::RST_CONTROL;
    end else if (accept_wr && hit(idx, dtc_pkg::IDX_CONTROL)) begin
      control <= avs_writedata[5:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mask <= dtc_pkg::RST_FLAGS;
    end else if (accept_wr && hit(idx, dtc_pkg::IDX_MASK)) begin
      mask <= avs_writedata[1:0];
    end
  end

  // Set beats a same-cycle write-one-to-clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      overflow_flag <= dtc_pkg::RST_FLAGS;
    end else begin
      overflow_flag <= (overflow_flag &
          ~((accept_wr && hit(idx, dtc_pkg::IDX_STATUS)) ? avs_writedata[1:0] : 2'h0))
          | ovf;
    end
  end

  // Registered, so it trails the flag by one cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(overflow_flag & mask);
    end
  end

  assign toggle[0] = ovf[0] && port_mode_and_toggle_enable[dtc_pkg::BIT_T0_TOGGLE_EN];
  assign toggle[1] = ovf[1] && port_mode_and_toggle_enable[dtc_pkg::BIT_T1_TOGGLE_EN];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer0_toggle_out <= 1'b0;
      timer1_toggle_out <= 1'b0;
    end else begin
      timer0_toggle_out <= timer0_toggle_out ^ toggle[0];
      timer1_toggle_out <= timer1_toggle_out ^ toggle[1];
    end
  end

  // Snapshot taken in the wait cycle, stable at acceptance
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= '0;
    end else if (capture_rd) begin
      case (idx)
        dtc_pkg::IDX_T0_LOW: avs_readdata <= {24'h000000, lows[0]};
        dtc_pkg::IDX_T1_LOW: avs_readdata <= {24'h000000, lows[1]};
        dtc_pkg::IDX_T0_HIGH: avs_readdata <= {24'h000000, highs[0]};
        dtc_pkg::IDX_T1_HIGH: avs_readdata <= {24'h000000, highs[1]};
        dtc_pkg::IDX_PORT_MODE: avs_readdata <= {24'h000000, port_mode_and_toggle_enable};
        dtc_pkg::IDX_CONTROL: avs_readdata <= {26'h0000000, control};
        dtc_pkg::IDX_STATUS: avs_readdata <= {30'h00000000, overflow_flag};
        dtc_pkg::IDX_MASK: avs_readdata <= {30'h00000000, mask};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule

/* testbench/dtc_checker.sv */
`timescale 1ns/10ps
module dtc_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [dtc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [dtc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [dtc_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  input wire logic external_gate_pin0,
  input wire logic external_gate_pin1,
  input wire logic timer0_toggle_out,
  input wire logic timer1_toggle_out,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_access; s_req |=> s_ans; endproperty
  a_access: assert property (p_access) else $error("wait cycle count wrong");
  property p_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_upper; !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_stands; $changed(avs_readdata) |-> $past(avs_read); endproperty
  a_stands: assert property (p_stands) else $error("read data moved");
  property p_rst;
    $rose(rstn) |-> avs_waitrequest && !irq && !timer0_toggle_out && !timer1_toggle_out;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_irq_fall; $fell(irq) |-> $past(avs_write, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
  property p_tog0; $changed(timer0_toggle_out) |=> $stable(timer0_toggle_out) [*8]; endproperty
  a_tog0: assert property (p_tog0) else $error("toggle 0 too fast");
  property p_tog1; $changed(timer1_toggle_out) |=> $stable(timer1_toggle_out) [*8]; endproperty
  a_tog1: assert property (p_tog1) else $error("toggle 1 too fast");
endmodule
bind dtc_top dtc_checker chk (.clock(clock), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .timer0_count_pin(timer0_count_pin), .timer1_count_pin(timer1_count_pin),
  .external_gate_pin0(external_gate_pin0), .external_gate_pin1(external_gate_pin1),
  .timer0_toggle_out(timer0_toggle_out), .timer1_toggle_out(timer1_toggle_out), .irq(irq));

/* testbench/dtc_pins.sv */
`timescale 1ns/10ps
module dtc_pins (
  input wire logic clock,
  output logic pin0,
  output logic pin1
);
  initial {pin0, pin1} = 2'h3;
  // Random hold lengths, never under the sync margin
  task automatic pulse(input int t, input int n);
    repeat (n) begin
      if (t) pin1 <= 1'b0; else pin0 <= 1'b0;
      repeat (2 + $urandom % 3) @(posedge clock);
      if (t) pin1 <= 1'b1; else pin0 <= 1'b1;
      repeat (2 + $urandom % 3) @(posedge clock);
    end
  endtask
endmodule

/* testbench/dual_timer_counter_mode0_bench.sv */
`timescale 1ns/10ps
module dual_timer_counter_mode0_bench;
  logic clock, rstn, avs_read, avs_write, avs_waitrequest, irq, g0, g1, p0, p1, o0, o1;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] regs [9] = '{8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h96, 8'ha0, 8'ha1, 8'ha2, 8'h10};
  int n_errors, n_compared, cyc, ta, s, d, lt[2], cn[2], tg[2];
  dtc_top uut (.clock(clock), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer0_count_pin(p0), .timer1_count_pin(p1),
    .external_gate_pin0(g0), .external_gate_pin1(g1), .timer0_toggle_out(o0),
    .timer1_toggle_out(o1), .irq(irq));
  dtc_pins pins (.clock(clock), .pin0(p0), .pin1(p1));
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 30000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Acceptance cycle kept in ta so run time is exact
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    ta = cyc;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] idx, input int e);
    bus(1'b0, idx, 32'h0);
    chk(q, e);
  endtask
  task automatic set(input int t, input int lo, input int hi);
    bus(1'b1, 8'(8'h8a + t), lo);
    bus(1'b1, 8'(8'h8c + t), hi);
    lt[t] = lo & 8'he0;
    cn[t] = hi * 32 + lo % 32;
  endtask
  task automatic adv(input int t, input int n);
    cn[t] += n;
    if (cn[t] > 8191) tg[t] ^= 1;
    cn[t] %= 8192;
  endtask
  task automatic cmp(input int t);
    rd(8'(8'h8a + t), lt[t] | cn[t] % 32);
    rd(8'(8'h8c + t), cn[t] / 32);
  endtask
  initial begin
    {clock, rstn, avs_read, avs_write, g0, g1} = '0;
    avs_address = '0;
    avs_writedata = '0;
    {cyc, n_errors, n_compared} = '0;
    tg = '{0, 0};
    q = $urandom(32'h066592f4);
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    foreach (regs[i]) rd(regs[i], 0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      d = $urandom;
      bus(1'b1, regs[i], d);
      rd(regs[i], d & 255);
    end
    bus(1'b1, 8'h10, 32'hff);
    rd(8'h10, 0);
    $display("test access done");
    bus(1'b1, 8'h96, 32'h0c);
    for (int t = 0; t < 2; t++) begin
      set(t, 8'hfd, 8'hff);
      bus(1'b1, 8'ha0, t ? 32'h22 : 32'h01);
      s = ta;
      if (t) pins.pulse(1, 10);
      else repeat (8) @(posedge clock);
      bus(1'b1, 8'ha0, 32'h0);
      adv(t, t ? 10 : ta - s);
      cmp(t);
      rd(8'ha1, 1 << t);
      chk(t ? o1 : o0, tg[t]);
      chk(irq, 0);
      bus(1'b1, 8'ha2, 32'h3);
      @(posedge clock);
      chk(irq, 1);
      bus(1'b1, 8'ha1, 1 << t);
      @(posedge clock);
      chk(irq, 0);
      bus(1'b1, 8'ha2, 32'h0);
    end
    $display("test overflow done");
    bus(1'b1, 8'ha0, 32'h05);
    repeat (5) @(posedge clock);
    bus(1'b1, 8'ha0, 32'h10);
    cmp(0);
    pins.pulse(0, 3);
    cmp(0);
    g0 <= 1'b1;
    bus(1'b1, 8'ha0, 32'h15);
    pins.pulse(0, 5);
    bus(1'b1, 8'ha0, 32'h0);
    adv(0, 5);
    cmp(0);
    bus(1'b1, 8'ha0, 32'h0a);
    repeat (4) @(posedge clock);
    bus(1'b1, 8'ha0, 32'h0);
    cmp(1);
    g1 <= 1'b1;
    repeat (3) @(posedge clock);
    bus(1'b1, 8'ha0, 32'h0a);
    s = ta;
    repeat (6) @(posedge clock);
    bus(1'b1, 8'ha0, 32'h0);
    adv(1, ta - s);
    cmp(1);
    $display("test gate done");
    finish_test();
  end
endmodule
